// ---- core/rcs_pkg.sv ----
package rcs_pkg;
  localparam logic [31:0] RCS_ADDR_CAUSE   = 32'h0000_0000;
  localparam logic [31:0] RCS_ADDR_OSC     = 32'h0000_0004;
  localparam logic [31:0] RCS_ADDR_STATUS  = 32'h0000_0008;
  localparam int RCS_BIT_TRAP   = 15;
  localparam int RCS_BIT_ILL    = 14;
  localparam int RCS_BIT_VREG   = 8;
  localparam int RCS_BIT_PIN    = 7;
  localparam int RCS_BIT_SOFT   = 6;
  localparam int RCS_BIT_WDEN   = 5;
  localparam int RCS_BIT_WATCHDOG_TIMEOUT_FLAG   = 4;
  localparam int RCS_BIT_SLEEP  = 3;
  localparam int RCS_BIT_IDLE   = 2;
  localparam int RCS_BIT_BOR    = 1;
  localparam int RCS_BIT_POR    = 0;
  localparam logic [15:0] RCS_CAUSE_MASK  = 16'hc1ff;
  localparam logic [15:0] RCS_CAUSE_RESET = 16'h0003;
  localparam logic [2:0]  RCS_OSC_FRC     = 3'h0;
  localparam logic [2:0]  RCS_OSC_FRCPLL  = 3'h1;
  localparam logic [2:0]  RCS_OSC_XT      = 3'h2;
  localparam logic [2:0]  RCS_OSC_XTPLL   = 3'h3;
  localparam logic [2:0]  RCS_OSC_SOSC    = 3'h4;
  localparam int RCS_CLK_MHZ       = 20;
  localparam int RCS_POWERON_DELAY_US       = 10;
  localparam int RCS_TSTART_REG_US = 20;
  localparam int RCS_TSTART_NOREG_MS = 64;
  localparam int RCS_TRST_US       = 20;
  localparam int RCS_TLOCK_US      = 20;
  localparam int RCS_TMON_US       = 100;
  localparam int RCS_OST_PERIODS   = 1024;
  localparam int RCS_POWERON_DELAY_CYC      = RCS_POWERON_DELAY_US * RCS_CLK_MHZ;
  localparam int RCS_TSTART_REG_CYC = RCS_TSTART_REG_US * RCS_CLK_MHZ;
  localparam int RCS_TSTART_NOREG_CYC = RCS_TSTART_NOREG_MS * 1000 * RCS_CLK_MHZ;
  localparam int RCS_TRST_CYC      = RCS_TRST_US * RCS_CLK_MHZ;
  localparam int RCS_TLOCK_CYC     = RCS_TLOCK_US * RCS_CLK_MHZ;
  localparam int RCS_TMON_CYC      = RCS_TMON_US * RCS_CLK_MHZ;
  typedef enum logic [4:0]
  {
    RCS_ST_PORD  = 5'b00001,
    RCS_ST_START = 5'b00010,
    RCS_ST_RST   = 5'b00100,
    RCS_ST_MON   = 5'b01000,
    RCS_ST_RUN   = 5'b10000
  } rcs_state_type;
endpackage

// ---- core/rcs_sequencer.sv ----
`timescale 1ns/1ps
module rcs_sequencer #(
  parameter int STARTUP_NOREG_CYC = rcs_pkg::RCS_TSTART_NOREG_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Reset sources and sleep/idle/wake events, one-cycle pulses or levels
  input  wire logic        por_event,
  input  wire logic        bor_event,
  input  wire logic        pin_reset_event,
  input  wire logic        wdt_timeout_event,
  input  wire logic        soft_reset_event,
  input  wire logic        trap_conflict_event,
  input  wire logic        illegal_op_event,
  input  wire logic        sleep_instr_event,
  input  wire logic        idle_instr_event,
  input  wire logic        wake_event,
  // Configuration and oscillator side
  input  wire logic [2:0]  cfg_oscillator_select,
  input  wire logic        cfg_clock_switch_en,
  input  wire logic        cfg_watchdog_force,
  input  wire logic        cfg_monitor_en,
  input  wire logic        regulator_en,
  input  wire logic        osc_tick,
  input  wire logic        osc_valid,
  // Outputs to core
  output logic             system_reset_signal,
  output logic             clock_released,
  output logic             cpu_run,
  output logic             monitor_active,
  output logic             watchdog_enable,
  output logic             regulator_sleep_keep,
  output logic [2:0]       current_oscillator_select,
  // AXI4-Lite slave
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [15:0]           cause;
    logic [2:0]            osc;
    rcs_pkg::rcs_state_type st;
    logic [31:0]           dly;
    logic [10:0]           oscillator_startup_timer;
    logic [31:0]           lock;
    logic                  clk_ok;
    logic                  mon;
    logic                  aw_got;
    logic [31:0]           aw_addr;
    logic                  w_got;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } rcs_regs_type;

  // One register holds all state so reset is one clear, with cause and state then set
  rcs_regs_type q_r;
  rcs_regs_type q_nxt;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Widen a cycle count for the 32-bit timers
  function automatic logic [31:0] rcs_cyc(input int n);
    rcs_cyc = 32'(n);
  endfunction

  // Sources that need the start-up count
  function automatic logic rcs_is_xtal(input logic [2:0] s);
    rcs_is_xtal = (s == rcs_pkg::RCS_OSC_XT) || (s == rcs_pkg::RCS_OSC_XTPLL)
                  || (s == rcs_pkg::RCS_OSC_SOSC);
  endfunction

  // Sources that need the lock wait
  function automatic logic rcs_is_pll(input logic [2:0] s);
    rcs_is_pll = (s == rcs_pkg::RCS_OSC_FRCPLL) || (s == rcs_pkg::RCS_OSC_XTPLL);
  endfunction

  function automatic logic [15:0] rcs_merge(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
    // Lanes 2 and 3 carry nothing in a 16-bit register
    rcs_merge = old;
    if (be[0])
      rcs_merge[7:0] = d[7:0];
    if (be[1])
      rcs_merge[15:8] = d[15:8];
  endfunction

  // ****************************************************************
  // Reset classes and bus readiness
  // ****************************************************************
  logic        long_rst;
  logic        short_rst;
  logic        any_rst;
  logic        aw_fire;
  logic        w_fire;
  logic        ar_fire;
  logic        wr_go;
  logic [15:0] sw_cause;
  logic [15:0] hw_set;

  // Power-on and brown-out take the full delay chain, the rest only internal
  assign long_rst  = por_event | bor_event;
  assign short_rst = pin_reset_event | wdt_timeout_event | soft_reset_event
                     | trap_conflict_event | illegal_op_event;
  assign any_rst   = long_rst | short_rst;

  assign s_axi_awready = !q_r.aw_got && !q_r.bvalid;
  assign s_axi_wready  = !q_r.w_got && !q_r.bvalid;
  assign s_axi_arready = !q_r.rvalid;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire  = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic [2:0] sel;
    logic [31:0] wa;
    logic [31:0] wd;
    logic [3:0]  wb;
    sel = '0;
    wa = '0;
    wd = '0;
    wb = '0;
    q_nxt = q_r;
    hw_set = '0;
    sw_cause = '0;
    wr_go = 1'b0;

    // Bus write: both halves held until paired, response follows both
    if (aw_fire)
    begin
      q_nxt.aw_got  = 1'b1;
      q_nxt.aw_addr = s_axi_awaddr;
    end
    if (w_fire)
    begin
      q_nxt.w_got  = 1'b1;
      q_nxt.w_data = s_axi_wdata;
      q_nxt.w_strb = s_axi_wstrb;
    end
    wa = aw_fire ? s_axi_awaddr : q_r.aw_addr;
    wd = w_fire ? s_axi_wdata : q_r.w_data;
    wb = w_fire ? s_axi_wstrb : q_r.w_strb;
    if ((q_r.aw_got || aw_fire) && (q_r.w_got || w_fire))
    begin
      wr_go = 1'b1;
      q_nxt.aw_got = 1'b0;
      q_nxt.w_got  = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp  = 2'h0;
      if (wa[31:2] == rcs_pkg::RCS_ADDR_CAUSE[31:2])
        sw_cause = rcs_merge(q_r.cause, wd, wb) & rcs_pkg::RCS_CAUSE_MASK;
      else if (wa[31:2] == rcs_pkg::RCS_ADDR_OSC[31:2])
      begin
        if (wb[0])
          q_nxt.osc = wd[2:0];
      end
      else if (wa[31:2] != rcs_pkg::RCS_ADDR_STATUS[31:2])
        q_nxt.bresp = 2'h2;
    end
    if (q_r.bvalid && s_axi_bready)
      q_nxt.bvalid = 1'b0;

    // Software writes the strobed bytes of the field, then hardware events win over it
    if (wr_go && (wa[31:2] == rcs_pkg::RCS_ADDR_CAUSE[31:2]))
      q_nxt.cause = sw_cause;
    hw_set[rcs_pkg::RCS_BIT_TRAP]  = trap_conflict_event;
    hw_set[rcs_pkg::RCS_BIT_ILL]   = illegal_op_event;
    hw_set[rcs_pkg::RCS_BIT_PIN]   = pin_reset_event;
    hw_set[rcs_pkg::RCS_BIT_SOFT]  = soft_reset_event;
    hw_set[rcs_pkg::RCS_BIT_WATCHDOG_TIMEOUT_FLAG]  = wdt_timeout_event;
    hw_set[rcs_pkg::RCS_BIT_SLEEP] = sleep_instr_event;
    hw_set[rcs_pkg::RCS_BIT_IDLE]  = idle_instr_event;
    hw_set[rcs_pkg::RCS_BIT_BOR]   = long_rst;
    hw_set[rcs_pkg::RCS_BIT_POR]   = por_event;
    if (sleep_instr_event || idle_instr_event)
      q_nxt.cause[rcs_pkg::RCS_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
    if (long_rst)
    begin
      // Brown-out spares pin, VREG, WDEN and POR flags; power-on clears everything but the POR and BOR flags
      q_nxt.cause[rcs_pkg::RCS_BIT_TRAP]  = 1'b0;
      q_nxt.cause[rcs_pkg::RCS_BIT_ILL]   = 1'b0;
      q_nxt.cause[rcs_pkg::RCS_BIT_SOFT]  = 1'b0;
      q_nxt.cause[rcs_pkg::RCS_BIT_WATCHDOG_TIMEOUT_FLAG]  = 1'b0;
      q_nxt.cause[rcs_pkg::RCS_BIT_SLEEP] = 1'b0;
      q_nxt.cause[rcs_pkg::RCS_BIT_IDLE]  = 1'b0;
      if (por_event)
      begin
        q_nxt.cause[rcs_pkg::RCS_BIT_PIN]  = 1'b0;
        q_nxt.cause[rcs_pkg::RCS_BIT_VREG] = 1'b0;
        q_nxt.cause[rcs_pkg::RCS_BIT_WDEN] = 1'b0;
      end
    end
    q_nxt.cause = (q_nxt.cause | hw_set) & rcs_pkg::RCS_CAUSE_MASK;

    // Clock source chosen per reset type
    sel = q_r.osc;
    if (!cfg_clock_switch_en || long_rst)
      sel = cfg_oscillator_select;
    if (any_rst)
      q_nxt.osc = sel;

    // Oscillator start-up and PLL lock run beside the reset delays
    if (any_rst)
    begin
      q_nxt.oscillator_startup_timer    = '0;
      q_nxt.lock   = '0;
      q_nxt.clk_ok = !long_rst || !(rcs_is_xtal(sel) || rcs_is_pll(sel));
      q_nxt.mon    = 1'b0;
    end
    else if ((q_r.st == rcs_pkg::RCS_ST_PORD) && (q_r.dly == 32'h0))
    begin
      // Async reset counts as power-on but cannot load the source itself
      q_nxt.osc    = cfg_oscillator_select;
      q_nxt.clk_ok = !(rcs_is_xtal(cfg_oscillator_select)
                       || rcs_is_pll(cfg_oscillator_select));
    end
    else if (!q_r.clk_ok)
    begin
      if (rcs_is_xtal(q_r.osc) && osc_tick && !q_r.oscillator_startup_timer[10])
        q_nxt.oscillator_startup_timer = q_r.oscillator_startup_timer + 11'h001;
      if (rcs_is_pll(q_r.osc) && !(q_r.lock >= rcs_cyc(rcs_pkg::RCS_TLOCK_CYC)))
        q_nxt.lock = q_r.lock + 32'h1;
      if ((!rcs_is_xtal(q_r.osc) || q_r.oscillator_startup_timer[10])
          && (!rcs_is_pll(q_r.osc) || (q_r.lock >= rcs_cyc(rcs_pkg::RCS_TLOCK_CYC))))
        q_nxt.clk_ok = 1'b1;
    end

    // Reset delay chain
    q_nxt.dly = q_r.dly + 32'h1;
    if (long_rst)
    begin
      q_nxt.st  = rcs_pkg::RCS_ST_PORD;
      q_nxt.dly = '0;
    end
    else if (short_rst)
    begin
      q_nxt.st  = rcs_pkg::RCS_ST_RST;
      q_nxt.dly = '0;
    end
    else if (wake_event && regulator_en && (q_r.st == rcs_pkg::RCS_ST_RUN))
    begin
      q_nxt.st  = rcs_pkg::RCS_ST_START;
      q_nxt.dly = '0;
    end
    else
    begin
      unique case (q_r.st)
        rcs_pkg::RCS_ST_PORD:
          if (q_r.dly >= rcs_cyc(rcs_pkg::RCS_POWERON_DELAY_CYC - 1))
          begin
            q_nxt.st  = rcs_pkg::RCS_ST_START;
            q_nxt.dly = '0;
          end
        rcs_pkg::RCS_ST_START:
          if (q_r.dly >= (regulator_en ? rcs_cyc(rcs_pkg::RCS_TSTART_REG_CYC - 1)
                                       : rcs_cyc(STARTUP_NOREG_CYC - 1)))
          begin
            q_nxt.st  = rcs_pkg::RCS_ST_RST;
            q_nxt.dly = '0;
          end
        rcs_pkg::RCS_ST_RST:
          if (q_r.dly >= rcs_cyc(rcs_pkg::RCS_TRST_CYC - 1))
          begin
            q_nxt.st  = rcs_pkg::RCS_ST_MON;
            q_nxt.dly = '0;
          end
        rcs_pkg::RCS_ST_MON:
          // Crystal/PLL sources get settling time before the monitor looks
          if (!(rcs_is_xtal(q_r.osc) || rcs_is_pll(q_r.osc))
              || q_r.dly >= rcs_cyc(rcs_pkg::RCS_TMON_CYC - 1))
          begin
            q_nxt.st  = rcs_pkg::RCS_ST_RUN;
            q_nxt.mon = cfg_monitor_en;
            if (cfg_monitor_en && !(q_r.clk_ok && osc_valid))
            begin
              q_nxt.osc    = rcs_pkg::RCS_OSC_FRC;
              q_nxt.clk_ok = 1'b1;
            end
          end
        rcs_pkg::RCS_ST_RUN:
          // Counter parked so it cannot wrap while running
          q_nxt.dly = q_r.dly;
      endcase
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************
    if (q_r.rvalid && s_axi_rready)
      q_nxt.rvalid = 1'b0;
    if (ar_fire)
    begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp  = 2'h0;
      q_nxt.rdata  = '0;
      if (s_axi_araddr[31:2] == rcs_pkg::RCS_ADDR_CAUSE[31:2])
        q_nxt.rdata = {16'h0000, q_r.cause & rcs_pkg::RCS_CAUSE_MASK};
      else if (s_axi_araddr[31:2] == rcs_pkg::RCS_ADDR_OSC[31:2])
        q_nxt.rdata = {29'h0, q_r.osc};
      else if (s_axi_araddr[31:2] == rcs_pkg::RCS_ADDR_STATUS[31:2])
        q_nxt.rdata = {26'h0, q_r.st == rcs_pkg::RCS_ST_RUN, q_r.mon,
                       q_r.clk_ok, q_r.st != rcs_pkg::RCS_ST_RUN, 2'h0};
      else
        q_nxt.rresp = 2'h2;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q_r        <= '0;
      q_r.cause  <= rcs_pkg::RCS_CAUSE_RESET;
      q_r.st     <= rcs_pkg::RCS_ST_PORD;
    end
    else
      q_r <= q_nxt;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign system_reset_signal = (q_r.st == rcs_pkg::RCS_ST_PORD) || (q_r.st == rcs_pkg::RCS_ST_START)
                               || (q_r.st == rcs_pkg::RCS_ST_RST);
  assign clock_released = q_r.clk_ok;
  // Reset may end before a crystal has started; the core waits for both
  assign cpu_run        = !system_reset_signal && q_r.clk_ok;
  assign monitor_active = q_r.mon;
  assign watchdog_enable = q_r.cause[rcs_pkg::RCS_BIT_WDEN] | cfg_watchdog_force;
  assign regulator_sleep_keep = q_r.cause[rcs_pkg::RCS_BIT_VREG];
  assign current_oscillator_select = q_r.osc;
  assign s_axi_bvalid = q_r.bvalid;
  assign s_axi_bresp  = q_r.bresp;
  assign s_axi_rvalid = q_r.rvalid;
  assign s_axi_rdata  = q_r.rdata;
  assign s_axi_rresp  = q_r.rresp;

endmodule

// ---- testbench/rcs_osc_model.sv ----
`timescale 1ns/1ps
// ****************
// Crystal side
// ****************
// Ticks only while oscillating; a stopped crystal gives no stale tick
module rcs_osc_model #(
  parameter int DIV = 2
) (
  // Clock and control
  input  wire logic core_clk,
  input  wire logic osc_on,
  // Oscillator status
  output logic      osc_tick = 1'b0,
  output logic      osc_valid = 1'b0
);
  int ph = 0;
  always @(posedge core_clk)
  begin
    ph <= (ph + 1) % DIV;
    osc_tick <= osc_on && (ph == 0);
    osc_valid <= osc_on;
  end
endmodule

// ---- testbench/rcs_checker.sv ----
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module rcs_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Reset sources
  input wire logic por_event,
  input wire logic bor_event,
  input wire logic pin_reset_event,
  input wire logic wdt_timeout_event,
  input wire logic soft_reset_event,
  input wire logic trap_conflict_event,
  input wire logic illegal_op_event,
  input wire logic wake_event,
  // Core side
  input wire logic cfg_watchdog_force,
  input wire logic system_reset_signal,
  input wire logic clock_released,
  input wire logic cpu_run,
  input wire logic watchdog_enable,
  // Register bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic        ev;
  logic        short_r;
  logic [11:0] cnt_r;
  assign ev = por_event | bor_event | pin_reset_event | wdt_timeout_event
    | soft_reset_event | trap_conflict_event | illegal_op_event | wake_event;
  // Cycles since the last source, saturating
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r <= 12'h000;
      short_r <= 1'b0;
    end
    else
    begin
      if (ev) cnt_r <= 12'h000;
      else if (cnt_r != 12'hfff) cnt_r <= cnt_r + 12'h001;
      if (por_event | bor_event | wake_event) short_r <= 1'b0;
      else if (ev & ~wake_event) short_r <= 1'b1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_src; (ev & ~wake_event) |-> ##1 system_reset_signal [*8]; endproperty
  property p_run; cpu_run |-> clock_released && !system_reset_signal; endproperty
  property p_wdf; cfg_watchdog_force |-> watchdog_enable; endproperty
  property p_min; $fell(system_reset_signal) |-> cnt_r >= 12'h190; endproperty
  property p_max; (short_r && cnt_r == 12'h193) |-> !system_reset_signal; endproperty
  property p_sw; (s_axi_bvalid && !ev && !system_reset_signal) |=> !system_reset_signal;
  endproperty
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_src: assert property (p_src) else $error("source did not hold reset");
  a_run: assert property (p_run) else $error("running without clock");
  a_wdf: assert property (p_wdf) else $error("forced watchdog off");
  a_min: assert property (p_min) else $error("reset released early");
  a_max: assert property (p_max) else $error("reset released late");
  a_sw: assert property (p_sw) else $error("register write caused reset");
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  c_short: cover property ($fell(system_reset_signal) && short_r);
  c_run: cover property ($rose(cpu_run));
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind rcs_sequencer rcs_checker u_chk (.core_clk, .resetn, .por_event, .bor_event,
  .pin_reset_event, .wdt_timeout_event, .soft_reset_event, .trap_conflict_event,
  .illegal_op_event, .wake_event, .cfg_watchdog_force, .system_reset_signal,
  .clock_released, .cpu_run, .watchdog_enable, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rvalid, .s_axi_rready);

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  // ****************
  // Signals
  // ****************
  typedef struct {int idx; logic rst; logic [31:0] cause;} rcs_row_type;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [9:0]  ev = 10'h000;
  logic [2:0]  cfg_oscillator_select = 3'h0;
  logic        cfg_clock_switch_en = 1'b1;
  logic        cfg_watchdog_force = 1'b0;
  logic        cfg_monitor_en = 1'b0;
  logic        regulator_en = 1'b1;
  logic        osc_on = 1'b1;
  logic        osc_tick, osc_valid;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        system_reset_signal, clock_released, cpu_run, watchdog_enable;
  logic        regulator_sleep_keep;
  logic [2:0]  current_oscillator_select;
  int          miscompares = 0;
  int          checked = 0;
  // Flags accumulate: sleep wipes the watchdog flag
  rcs_row_type rows [7] = '{'{2, 1'b1, 32'h80}, '{3, 1'b1, 32'h90}, '{4, 1'b1, 32'hd0},
    '{5, 1'b1, 32'h80d0}, '{6, 1'b1, 32'hc0d0}, '{7, 1'b0, 32'hc0c8}, '{8, 1'b0, 32'hc0cc}};
  rcs_sequencer #(.STARTUP_NOREG_CYC(50)) u_dut (.core_clk, .resetn, .por_event(ev[0]),
    .bor_event(ev[1]), .pin_reset_event(ev[2]), .wdt_timeout_event(ev[3]),
    .soft_reset_event(ev[4]), .trap_conflict_event(ev[5]), .illegal_op_event(ev[6]),
    .sleep_instr_event(ev[7]), .idle_instr_event(ev[8]), .wake_event(ev[9]),
    .cfg_oscillator_select, .cfg_clock_switch_en, .cfg_watchdog_force, .cfg_monitor_en,
    .regulator_en, .osc_tick, .osc_valid, .system_reset_signal, .clock_released, .cpu_run,
    .monitor_active(), .watchdog_enable, .regulator_sleep_keep, .current_oscillator_select,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp(), .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  rcs_osc_model u_osc (.core_clk, .osc_on, .osc_tick, .osc_valid);
  initial
    forever #25 core_clk = ~core_clk;
  // ****************
  // Tasks
  // ****************
  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int c);
    if (c >= 9000)
    begin
      miscompares++;
      finish_test();
    end
  endtask
  task automatic pulse(input int i);
    @(posedge core_clk);
    ev[i] <= 1'b1;
    @(posedge core_clk);
    ev[i] <= 1'b0;
  endtask
  task automatic hold_len(output int c);
    c = 0;
    do
    begin
      @(posedge core_clk);
      c++;
    end
    while (system_reset_signal !== 1'b0 && c < 9000);
    tmo(c);
  endtask
  // Each valid held until its own handshake edge; answer taken when seen
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 9000);
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 9000);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask
  // ****************
  // Sequence
  // ****************
  initial
  begin
    int c;
    logic [31:0] d;
    logic [1:0] r;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    hold_len(c);
    cmp(32'(c > 999 && c < 1005), 32'h1);
    rd(rcs_pkg::RCS_ADDR_CAUSE, d, r);
    cmp(d, 32'(rcs_pkg::RCS_CAUSE_RESET));
    pulse(9);
    hold_len(c);
    cmp(32'(c > 400 && c < 803), 32'h1);
    wr(rcs_pkg::RCS_ADDR_CAUSE, 32'h0);
    foreach (rows[i])
    begin
      pulse(rows[i].idx);
      if (rows[i].rst)
      begin
        hold_len(c);
        cmp(32'(c - 1), 32'(rcs_pkg::RCS_TRST_CYC));
      end
      rd(rcs_pkg::RCS_ADDR_CAUSE, d, r);
      cmp(d, rows[i].cause);
    end
    wr(rcs_pkg::RCS_ADDR_CAUSE, 32'hffff_ffff);
    rd(rcs_pkg::RCS_ADDR_CAUSE, d, r);
    cmp(d, 32'(rcs_pkg::RCS_CAUSE_MASK));
    cmp(32'({system_reset_signal, regulator_sleep_keep, watchdog_enable}), 32'h3);
    wr(rcs_pkg::RCS_ADDR_CAUSE, 32'h0);
    cmp(32'({regulator_sleep_keep, watchdog_enable}), 32'h0);
    cfg_watchdog_force <= 1'b1;
    @(posedge core_clk);
    cmp(32'(watchdog_enable), 32'h1);
    rd(32'h0000_0010, d, r);
    cmp(32'(r), 32'h2);
    wr(rcs_pkg::RCS_ADDR_CAUSE, 32'hffff_ffff);
    pulse(1);
    hold_len(c);
    rd(rcs_pkg::RCS_ADDR_CAUSE, d, r);
    cmp(d, 32'h01a3);
    wr(rcs_pkg::RCS_ADDR_CAUSE, 32'hffff_ffff);
    regulator_en <= 1'b0;
    pulse(0);
    hold_len(c);
    cmp(32'(c > 650 && c < 655), 32'h1);
    rd(rcs_pkg::RCS_ADDR_CAUSE, d, r);
    cmp(d, 32'(rcs_pkg::RCS_CAUSE_RESET));
    regulator_en <= 1'b1;
    wr(rcs_pkg::RCS_ADDR_OSC, 32'h4);
    pulse(2);
    hold_len(c);
    cmp(32'(current_oscillator_select), 32'h4);
    cfg_oscillator_select <= rcs_pkg::RCS_OSC_XT;
    osc_on <= 1'b0;
    pulse(0);
    hold_len(c);
    cmp(32'({cpu_run, current_oscillator_select}), 32'(rcs_pkg::RCS_OSC_XT));
    osc_on <= 1'b1;
    c = 0;
    do
    begin
      @(posedge core_clk);
      c++;
    end
    while (cpu_run !== 1'b1 && c < 9000);
    tmo(c);
    cmp(32'(c > 2039 && c < 2060), 32'h1);
    cfg_monitor_en <= 1'b1;
    osc_on <= 1'b0;
    pulse(0);
    c = 0;
    do
    begin
      @(posedge core_clk);
      c++;
    end
    while (current_oscillator_select !== rcs_pkg::RCS_OSC_FRC && c < 9000);
    tmo(c);
    cmp(32'(c > 2999 && c < 3010), 32'h1);
    finish_test();
  end
endmodule
